// *** logic/drp_pkg.sv ***
// shared types and constants for the dma request/acknowledge port
package drp_pkg;
    localparam int DATA_WIDTH = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int BYTE_WIDTH = 8;
    localparam int LANE_HIGH_LSB = 8;
    localparam int SYNC_STAGES = 2;
    // least spacing of acknowledge rising edges in synchronous transfers
    localparam int ACK_SPACING_CYCLES = 2;
    localparam logic [1:0] LANES_NONE = 2'h0;
    localparam logic [1:0] LANES_LOW = 2'h1;
    localparam logic [1:0] LANES_HIGH = 2'h2;
    localparam logic [1:0] LANES_BOTH = 2'h3;

    // one unit in the fifo: data and which byte lanes it carries
    typedef struct packed {
        logic [1:0] lanes;
        logic [15:0] data;
    } drp_unit_type;

    localparam int UNIT_WIDTH = $bits(drp_unit_type);

    typedef enum logic [1:0] {
        DRP_IDLE = 2'b00,
        DRP_ACK = 2'b01,
        DRP_GAP = 2'b10
    } drp_state_type;
endpackage : drp_pkg

// *** logic/drp_fifo.sv ***
// synchronous fifo with valid/ready on both sides
module drp_fifo #(
    parameter int WIDTH = drp_pkg::UNIT_WIDTH,
    parameter int DEPTH = drp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;
    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    assign level = count;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : drp_fifo

// *** logic/drp_sync.sv ***
// two flip-flop synchroniser, one per bit
module drp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= RESET_VALUE;
            synced <= RESET_VALUE;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule : drp_sync

// *** logic/drp_port.sv ***
// dma request/acknowledge data port with an 8-unit fifo in the data path
//
// Overview of operation
// RULE1: request may stay high while fifo can take or give another unit
// RULE2: request drops when this acknowledge fills or empties the fifo
// RULE3: in single-bus setups register chip select stays inactive during acknowledge
// RULE4: non-burst: controller toggles acknowledge once per data access
// RULE5: this handshake applies only with alternate dma mode disabled
// RULE6: write strobe may lead or trail acknowledge; inside it is recommended; the port counts a strobe only if it rises while acknowledge is low
// RULE7: synchronous transfers space acknowledge rising edges two clocks apart
// RULE8: burst: acknowledge fall drops request only for a single transfer
// RULE9: burst multiple: request drops after the last strobe rises
// RULE10: burst: request re-rises after acknowledge only if pending
// RULE11: register write may lead or trail chip select; inside is recommended
// RULE12: single-bus: acknowledge inactive in register access; write strobes tied
// RULE13: no register-port fifo access while dma is running
// RULE14: byte control: high enable and address bit pick lanes per strobe
module drp_port #(
    parameter int DATA_WIDTH = drp_pkg::DATA_WIDTH,
    parameter int FIFO_DEPTH = drp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration
    input wire logic dmaEnable,
    input wire logic writeToDevice,
    input wire logic burstMode,
    input wire logic byteControl,
    input wire logic alternateDma,
    // dma pins
    output logic dma_request,
    input wire logic dma_acknowledge_n,
    input wire logic dma_bus_read_n,
    input wire logic dma_bus_write_n,
    input wire logic high_byte_enable,
    input wire logic low_byte_address_bit,
    input wire logic [DATA_WIDTH-1:0] dataIn,
    output logic [DATA_WIDTH-1:0] dataOut,
    output logic dataOutEnable_n,
    // internal side, toward the protocol engine
    output logic engValid,
    input wire logic engReady,
    output drp_pkg::drp_unit_type engUnit,
    input wire logic engInValid,
    output logic engInReady,
    input wire drp_pkg::drp_unit_type engInUnit,
    // status
    output logic [$clog2(FIFO_DEPTH):0] fifoLevel,
    output logic ackSpacingError,
    output drp_pkg::drp_state_type portState
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // synchronised pin inputs
    logic [4:0] pinsSync;
    drp_sync #(
        .WIDTH(5),
        // acknowledge and strobes reset to their idle high level so no false edge follows reset
        .RESET_VALUE(5'h1C)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .async({dma_acknowledge_n, dma_bus_read_n, dma_bus_write_n,
                high_byte_enable, low_byte_address_bit}),
        .synced(pinsSync)
    );
    wire ackN = pinsSync[4];
    wire rdN = pinsSync[3];
    wire wrN = pinsSync[2];
    wire hbe = pinsSync[1];
    wire lba = pinsSync[0];

    logic ackPrev;
    logic rdPrev;
    logic wrPrev;
    wire ackFall = ackPrev && !ackN;
    wire ackRise = !ackPrev && ackN;
    wire rdRise = !rdPrev && rdN;
    wire wrRise = !wrPrev && wrN;
    // a strobe rising inside the acknowledge window ends one unit
    wire strobeEnd = !ackN && (writeToDevice ? wrRise : rdRise);

    // lane select; full word when byte control is off
    wire [1:0] laneSel = !byteControl ? drp_pkg::LANES_BOTH :
                         (!hbe && !lba) ? drp_pkg::LANES_BOTH :
                         (!hbe) ? drp_pkg::LANES_HIGH :
                         drp_pkg::LANES_LOW; // [RULE14]

    // fifo mux: write fills from pins, read fills from engine
    logic fInValid;
    logic fInReady;
    logic fOutValid;
    logic fOutReady;
    drp_pkg::drp_unit_type fInData;
    drp_pkg::drp_unit_type fOutData;
    logic [LW-1:0] level;

    drp_pkg::drp_unit_type pinUnit;
    assign pinUnit.lanes = laneSel;
    assign pinUnit.data = dataIn;

    wire active = dmaEnable && !alternateDma; // [RULE5]
    wire pinPush = active && writeToDevice && strobeEnd;
    wire pinPop = active && !writeToDevice && strobeEnd;

    assign fInValid = writeToDevice ? pinPush : engInValid;
    assign fInData = writeToDevice ? pinUnit : engInUnit;
    assign engInReady = !writeToDevice && fInReady;
    assign fOutReady = writeToDevice ? engReady : pinPop;
    assign engValid = writeToDevice && fOutValid;
    assign engUnit = fOutData;

    drp_fifo #(
        .WIDTH(drp_pkg::UNIT_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(fInValid),
        .inReady(fInReady),
        .inData(fInData),
        .outValid(fOutValid),
        .outReady(fOutReady),
        .outData(fOutData),
        .level(level)
    );
    assign fifoLevel = level;

    // room or data for one more unit after the present strobe
    wire canServe = writeToDevice ? fInReady : fOutValid; // [RULE1]
    wire lastUnit = writeToDevice ? (level == LW'(FIFO_DEPTH - 1)) : (level == LW'(1));
    wire servesOneMore = canServe && !(strobeEnd && lastUnit); // [RULE2]
    // pending means not empty on read and not full on write
    wire pending = active && canServe; // [RULE10]

    drp_pkg::drp_state_type state;
    drp_pkg::drp_state_type next_state;
    logic next_request;
    logic request;
    logic [1:0] unitsInAck;
    logic [1:0] next_unitsInAck;

    always_comb begin
        next_state = state;
        next_request = request;
        next_unitsInAck = unitsInAck;
        unique case (state)
            drp_pkg::DRP_IDLE: begin
                next_request = pending;
                next_unitsInAck = '0;
                if (ackFall && active) begin
                    next_state = drp_pkg::DRP_ACK;
                    // burst: only a lone unit of room or data drops the request at this edge
                    next_request = burstMode ? (canServe && !lastUnit) : servesOneMore; // [RULE8]
                end
            end
            drp_pkg::DRP_ACK: begin
                if (strobeEnd && unitsInAck != 2'h3) begin
                    next_unitsInAck = unitsInAck + 2'h1;
                end
                if (burstMode) begin
                    // request drops after final strobe, not at the edge
                    if (strobeEnd && !servesOneMore) begin
                        next_request = 1'b0; // [RULE9]
                    end
                end else if (strobeEnd) begin
                    next_request = servesOneMore; // [RULE2]
                end
                if (ackRise) begin
                    next_state = drp_pkg::DRP_GAP;
                    next_request = pending; // [RULE10]
                end
            end
            drp_pkg::DRP_GAP: begin
                next_request = pending;
                next_state = drp_pkg::DRP_IDLE;
            end
            default: begin
                next_state = drp_pkg::DRP_IDLE;
                next_request = 1'b0;
            end
        endcase
        if (!active) begin
            next_request = 1'b0;
        end
    end

    // spacing monitor for acknowledge rising edges
    logic [1:0] sinceRise;
    // sinceRise reads one less than the edge distance, so a legal spacing must not flag
    wire tooClose = ackRise && (sinceRise < 2'(drp_pkg::ACK_SPACING_CYCLES - 1)); // [RULE7]

    // read data is registered from the fifo head so it is stable at the strobe
    logic [DATA_WIDTH-1:0] readData;
    wire driveBus = active && !writeToDevice && !ackN && !rdN;

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= drp_pkg::DRP_IDLE;
            request <= 1'b0;
            unitsInAck <= '0;
            ackPrev <= 1'b1;
            rdPrev <= 1'b1;
            wrPrev <= 1'b1;
            sinceRise <= 2'h3;
            ackSpacingError <= 1'b0;
            readData <= '0;
            dataOutEnable_n <= 1'b1;
        end else begin
            state <= next_state;
            request <= next_request;
            unitsInAck <= next_unitsInAck;
            ackPrev <= ackN;
            rdPrev <= rdN;
            wrPrev <= wrN;
            if (ackRise) begin
                sinceRise <= '0;
            end else if (sinceRise != 2'h3) begin
                sinceRise <= sinceRise + 2'h1;
            end
            if (tooClose) begin
                ackSpacingError <= 1'b1;
            end
            readData <= fOutData.data;
            dataOutEnable_n <= !driveBus;
        end
    end

    assign dma_request = request;
    assign dataOut = readData;
    assign portState = state;
endmodule : drp_port

// *** bench/drp_port_chk.sv ***
// concurrent checks on the dma port pins and fifo status
module drp_port_chk #(
    parameter int FIFO_DEPTH = drp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // configuration and engine side
    input wire logic dmaEnable,
    input wire logic writeToDevice,
    input wire logic alternateDma,
    input wire logic engReady,
    // pins
    input wire logic dma_request,
    input wire logic dma_acknowledge_n,
    input wire logic dma_bus_write_n,
    input wire logic dataOutEnable_n,
    // status
    input wire logic [$clog2(FIFO_DEPTH):0] fifoLevel,
    input wire logic ackSpacingError
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_wr_pulse;
        !dma_acknowledge_n && !dma_bus_write_n ##1 !dma_acknowledge_n && dma_bus_write_n;
    endsequence

    a_write_take: assert property ((s_wr_pulse ##0 (writeToDevice && dmaEnable && !alternateDma && !engReady
        && fifoLevel < FIFO_DEPTH)) |-> ##[1:6] $changed(fifoLevel)) else $error("strobe did not move a unit");
    a_one_unit: assert property (fifoLevel <= $past(fifoLevel) + 1) else $error("level rose by more than one");
    a_drain_hold: assert property (writeToDevice && !engReady |=> fifoLevel >= $past(fifoLevel))
        else $error("level fell without engine");
    a_full_low: assert property ((writeToDevice && fifoLevel == FIFO_DEPTH)[*3] |=> !dma_request)
        else $error("request high with fifo full");
    a_empty_low: assert property ((!writeToDevice && fifoLevel == 0)[*3] |=> !dma_request)
        else $error("request high with fifo empty");
    a_alt_idle: assert property (alternateDma[*2] |=> !dma_request) else $error("request in alternate mode");
    a_off_idle: assert property (!dmaEnable[*2] |=> !dma_request) else $error("request while disabled");
    a_write_nodrive: assert property (writeToDevice[*2] |=> dataOutEnable_n) else $error("bus driven on write");
    a_no_false_err: assert property (dma_acknowledge_n[*3] |=> !$rose(ackSpacingError))
        else $error("spacing error without acknowledge");
endmodule : drp_port_chk

bind drp_port drp_port_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clk(clk),
    .rst(rst),
    .dmaEnable(dmaEnable),
    .writeToDevice(writeToDevice),
    .alternateDma(alternateDma),
    .engReady(engReady),
    .dma_request(dma_request),
    .dma_acknowledge_n(dma_acknowledge_n),
    .dma_bus_write_n(dma_bus_write_n),
    .dataOutEnable_n(dataOutEnable_n),
    .fifoLevel(fifoLevel),
    .ackSpacingError(ackSpacingError)
);

// *** bench/drp_dma_ctrl.sv ***
// behavioural external dma controller driving the handshake pins
module drp_dma_ctrl (
    // clock
    input wire logic clk,
    // handshake pins
    output logic dma_acknowledge_n,
    output logic dma_bus_read_n,
    output logic dma_bus_write_n,
    output logic high_byte_enable,
    output logic low_byte_address_bit,
    // data bus
    output logic [15:0] dataIn,
    input wire logic [15:0] dataOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] rdQ[$];
    // the model has no register port, so no register write or fifo access meets a transfer
    initial begin
        dma_acknowledge_n = 1'h1;
        dma_bus_read_n = 1'h1;
        dma_bus_write_n = 1'h1;
        high_byte_enable = 1'h0;
        low_byte_address_bit = 1'h0;
        dataIn = 16'hFFFF;
    end
    // one acknowledge cycle carrying n strobes, each strobe fully inside it
    task automatic run(input logic wr, input int n, input logic hbe, input logic lba, input logic [15:0] d);
        @(posedge clk) #1 dma_acknowledge_n = 1'h0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk) #1 high_byte_enable = hbe;
            low_byte_address_bit = lba;
            dataIn = d + 16'(i);
            @(posedge clk) #1 dma_bus_write_n = !wr;
            dma_bus_read_n = wr;
            repeat (4) @(posedge clk);
            // read data is taken off the edge, then the strobe is released
            #1;
            if (!wr) rdQ.push_back(dataOut);
            dma_bus_write_n = 1'h1;
            dma_bus_read_n = 1'h1;
            // lanes and data held well past the strobe's rise, as the port syncs it
            repeat (4) @(posedge clk);
            #1 dataIn = ~dataIn;
        end
        dma_acknowledge_n = 1'h1;
        repeat (4) @(posedge clk);
        #1;
    endtask : run
endmodule : drp_dma_ctrl

// *** bench/tb_top.sv ***
// self-checking bench for the dma request/acknowledge port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, dmaEnable, writeToDevice, burstMode, byteControl, alternateDma;
    logic dma_request, dma_acknowledge_n, dma_bus_read_n, dma_bus_write_n, high_byte_enable, low_byte_address_bit;
    logic [15:0] dataIn, dataOut;
    logic dataOutEnable_n, engValid, engReady, engInValid, engInReady, ackSpacingError;
    drp_pkg::drp_unit_type engUnit, engInUnit;
    drp_pkg::drp_state_type portState;
    logic [3:0] fifoLevel;
    int num_errors = 0;
    int check_count = 0;
    int got;

    drp_port dut (
        .clk(clk),
        .rst(rst),
        .dmaEnable(dmaEnable),
        .writeToDevice(writeToDevice),
        .burstMode(burstMode),
        .byteControl(byteControl),
        .alternateDma(alternateDma),
        .dma_request(dma_request),
        .dma_acknowledge_n(dma_acknowledge_n),
        .dma_bus_read_n(dma_bus_read_n),
        .dma_bus_write_n(dma_bus_write_n),
        .high_byte_enable(high_byte_enable),
        .low_byte_address_bit(low_byte_address_bit),
        .dataIn(dataIn),
        .dataOut(dataOut),
        .dataOutEnable_n(dataOutEnable_n),
        .engValid(engValid),
        .engReady(engReady),
        .engUnit(engUnit),
        .engInValid(engInValid),
        .engInReady(engInReady),
        .engInUnit(engInUnit),
        .fifoLevel(fifoLevel),
        .ackSpacingError(ackSpacingError),
        .portState(portState)
    );
    drp_dma_ctrl dma (
        .clk(clk),
        .dma_acknowledge_n(dma_acknowledge_n),
        .dma_bus_read_n(dma_bus_read_n),
        .dma_bus_write_n(dma_bus_write_n),
        .high_byte_enable(high_byte_enable),
        .low_byte_address_bit(low_byte_address_bit),
        .dataIn(dataIn),
        .dataOut(dataOut)
    );

    task automatic chk(input logic [17:0] a, input logic [17:0] e);
        check_count++;
        if (a !== e) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask : chk
    task automatic close_out();
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : ticks
    function automatic logic [1:0] lanesOf(input int i);
        return i[1] ? drp_pkg::LANES_LOW : (i[0] ? drp_pkg::LANES_HIGH : drp_pkg::LANES_BOTH);
    endfunction : lanesOf

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        close_out();
    end
    initial begin
        {rst, dmaEnable, writeToDevice, byteControl} = 4'hF;
        {burstMode, alternateDma, engReady, engInValid} = 4'h0;
        engInUnit = '0;
        ticks(10);
        rst = 1'h0;
        chk(dma_request, 1'h0);
        chk(dataOutEnable_n, 1'h1);
        ticks(4);
        // every lane choice, then single-transfer bursts in the second half
        for (int i = 0; i < 8; i++) begin
            burstMode = i[2];
            dma.run(1'h1, 1, i[1], i[0], 16'hA000 + 16'(i));
            if (i == 3) chk(dma_request, 1'h1);
        end
        chk(fifoLevel, 4'h8);
        chk(dma_request, 1'h0);
        engReady = 1'h1;
        got = 0;
        for (int k = 0; k < 200 && got < 8; k++) begin
            @(negedge clk);
            if (engValid === 1'h1) begin
                chk(engUnit, {lanesOf(got), 16'hA000 + 16'(got)});
                got++;
            end
        end
        ticks(1);
        engReady = 1'h0;
        chk(18'(got), 18'h8);
        writeToDevice = 1'h0;
        byteControl = 1'h0;
        engInValid = 1'h1;
        for (int k = 0; k < 4; k++) begin
            engInUnit = {drp_pkg::LANES_BOTH, 16'hC000 + 16'(k)};
            ticks(1);
        end
        engInValid = 1'h0;
        ticks(4);
        chk(fifoLevel, 4'h4);
        chk(engInReady, 1'h1);
        chk(dma_request, 1'h1);
        // burst of four reads: request holds through the burst and drops after the last strobe
        fork
            dma.run(1'h0, 4, 1'h0, 1'h0, 16'h0000);
            begin
                ticks(31);
                chk(dma_request, 1'h1);
                chk(portState, drp_pkg::DRP_ACK);
                ticks(5);
                chk(dataOutEnable_n, 1'h0);
                ticks(5);
                chk(dma_request, 1'h0);
            end
        join
        chk(dma_request, 1'h0);
        chk(18'(dma.rdQ.size()), 18'h4);
        for (int k = 0; k < 4; k++) chk(dma.rdQ[k], 16'hC000 + 16'(k));
        writeToDevice = 1'h1;
        alternateDma = 1'h1;
        ticks(5);
        chk(dma_request, 1'h0);
        alternateDma = 1'h0;
        dmaEnable = 1'h0;
        ticks(5);
        chk(dma_request, 1'h0);
        dmaEnable = 1'h1;
        ticks(5);
        chk(dma_request, 1'h1);
        chk(ackSpacingError, 1'h0);
        chk(portState, drp_pkg::DRP_IDLE);
        close_out();
    end
endmodule : tb_top
